// ==== logic/pbm_consts.svh ====
/*
  constants for the basic mode control upper bits: address, bit positions,
  reset values and the software reset duration.
  assumes a 25 MHz management clock.
*/
`ifndef PBM_CONSTS_SVH
`define PBM_CONSTS_SVH

`define PBM_ADDR_BMC        5'h00
`define PBM_BIT_RESET       15
`define PBM_BIT_LOOPBACK    14
`define PBM_BIT_SPEED       13
`define PBM_BIT_AN_EN       12
`define PBM_BIT_PWRDN       11
`define PBM_BIT_ISOLATE     10
`define PBM_BIT_DUPLEX      8
`define PBM_RST_LOOPBACK    1'h0
`define PBM_RST_SPEED       1'h1
`define PBM_RST_AN_EN       1'h1
`define PBM_RST_PWRDN       1'h0
`define PBM_RST_ISOLATE     1'h0
`define PBM_RST_DUPLEX      1'h1
`define PBM_CLK_MHZ         25
`define PBM_SRST_TIME_NS    1000
`define PBM_SRST_CYC        ((`PBM_SRST_TIME_NS * `PBM_CLK_MHZ + 999) / 1000)

`endif

// ==== logic/pbm_pkg.sv ====
/*
  types shared by the control register block.
  assumes nothing beyond the constants header.
*/
package pbm_pkg;
  typedef enum logic [1:0] {
    PBM_IDLE = 2'b01,
    PBM_BUSY = 2'b10
  } pbm_seq_t;
endpackage

// ==== logic/pbm_rst_seq.sv ====
/*
  software reset sequencer: holds busy for a fixed number of cycles after start
  and pulses done on the last one.
  assumes start is a one-cycle pulse in the clk_sys domain.
*/
`timescale 1ns/1ps
`include "pbm_consts.svh"

module pbm_rst_seq
  import pbm_pkg::*;
(
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rstn,
  // control
  input  wire logic start,
  output logic      busy,
  output logic      done
);

  localparam logic [7:0] CYC = 8'(`PBM_SRST_CYC);

  pbm_seq_t   state_ff;
  pbm_seq_t   nxt_state;
  logic [7:0] cnt_ff;
  logic [7:0] nxt_cnt;
  wire        last = (cnt_ff == CYC - 8'h01);

  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    unique case (state_ff)
      PBM_IDLE:
      begin
        nxt_cnt = 8'h00;
        if (start)
          nxt_state = PBM_BUSY;
      end
      PBM_BUSY:
      begin
        nxt_cnt = cnt_ff + 8'h01;
        if (last)
          nxt_state = PBM_IDLE;
      end
      default:
      begin
        nxt_state = PBM_IDLE;
        nxt_cnt   = 8'h00;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      state_ff <= PBM_IDLE;
      cnt_ff   <= 8'h00;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
    end
  end

  assign busy = (state_ff == PBM_BUSY);
  assign done = (state_ff == PBM_BUSY) && last;

endmodule // pbm_rst_seq

// ==== logic/pbm_ctrl.sv ====
/*
  upper bits of the basic mode control register with their effect on the
  MII path: soft reset, loopback, forced speed, auto-negotiation enable,
  power down and isolate, plus the forced duplex bit.
  assumes a management engine decoding serial frames into a simple
  register port, and a receive/transmit datapath on the line side.
*/
`timescale 1ns/1ps
`include "pbm_consts.svh"

// Operation
// RULE_01: writing 1 to bit 15 starts a software reset that restores the configuration and then clears bit 15 itself.
// RULE_02: bit 15 reads 1 while the software reset runs, 0 otherwise, and is 0 after reset.
// RULE_03: with bit 14 set the MII transmit data is looped back onto the MII receive data, otherwise data flows normally; default 0.
// RULE_04: with auto-negotiation off, bit 13 forces 100Mbs when 1 and 10Mbs when 0; default 1.
// RULE_05: bit 12 set (default) enables auto-negotiation and makes bits 13 and 8 ignored, cleared it lets them set speed and duplex.
// RULE_06: bit 11 set puts the device into power down with only register access left working; default 0.
// RULE_07: power down is requested by bit 11 or the low power-down pin, and the low pin also sets bit 11.
// RULE_08: bit 10 set isolates the port from the MII while management keeps working; default 0.
// RULE_09: with auto-negotiation off bit 8 selects full duplex when 1 and half when 0, its reset value coming from a strap.
// RULE_10: while isolated the receive-side MII outputs are released and the transmit inputs ignored.
module pbm_ctrl
  import pbm_pkg::*;
(
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  // register port from the management engine
  input  wire logic       reg_sel,
  input  wire logic       reg_we,
  input  wire logic [4:0] reg_addr,
  input  wire logic [15:0] reg_wdata,
  output logic [15:0]     reg_rdata,
  // pins
  input  wire logic       irq_powerdown_pin_n,
  input  wire logic       duplex_strap,
  // auto-negotiation results
  input  wire logic       an_speed_100,
  input  wire logic       an_full_duplex,
  // MII from the MAC
  input  wire logic       mii_tx_en,
  input  wire logic [3:0] mii_txd,
  // MII to the MAC, three-state
  output logic [3:0]      mii_rxd,
  output logic            mii_rx_dv,
  output logic            mii_rx_oe,
  // line datapath
  input  wire logic [3:0] line_rxd,
  input  wire logic       line_rx_dv,
  output logic [3:0]      line_txd,
  output logic            line_tx_en,
  // status to the rest of the device
  output logic            speed_100,
  output logic            full_duplex,
  output logic            power_down,
  output logic            soft_reset
);

  logic        loopback_ff;
  logic        speed_ff;
  logic        an_en_ff;
  logic        pwrdn_ff;
  logic        isolate_ff;
  logic        duplex_ff;
  logic        strap_pend_ff;
  logic [15:0] rdata_ff;
  logic [3:0]  rxd_ff;
  logic        rx_dv_ff;
  logic [3:0]  txd_ff;
  logic        tx_en_ff;
  logic        rst_busy;
  logic        rst_done;

  // decode
  wire hit      = reg_sel && (reg_addr == `PBM_ADDR_BMC);
  wire wr_hit   = hit && reg_we && !rst_busy;
  wire rd_req   = reg_sel && !reg_we;
  wire rst_go   = wr_hit && reg_wdata[`PBM_BIT_RESET]; // [RULE_01]
  wire pin_pd   = !irq_powerdown_pin_n;
  wire pd_req   = pwrdn_ff || pin_pd; // [RULE_07]
  wire live     = !pd_req && !rst_busy; // [RULE_06]

  // writes steal no cycle from the reset sequencer; a write while it runs is ignored
  pbm_rst_seq u_rst_seq (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .start   (rst_go),
    .busy    (rst_busy),
    .done    (rst_done)
  );

  wire [15:0] rd_word = {rst_busy,   // [RULE_02]
                         loopback_ff,
                         speed_ff,
                         an_en_ff,
                         pwrdn_ff,
                         isolate_ff,
                         1'b0,
                         duplex_ff,
                         8'h00};
  wire [15:0] nxt_rdata = (reg_addr == `PBM_ADDR_BMC) ? rd_word : 16'h0000;

  // pin set beats a software clear in the same cycle
  wire nxt_pwrdn = pin_pd ? 1'b1 :
                   wr_hit ? reg_wdata[`PBM_BIT_PWRDN] : pwrdn_ff; // [RULE_07]

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      loopback_ff   <= `PBM_RST_LOOPBACK;
      speed_ff      <= `PBM_RST_SPEED;
      an_en_ff      <= `PBM_RST_AN_EN;
      pwrdn_ff      <= `PBM_RST_PWRDN;
      isolate_ff    <= `PBM_RST_ISOLATE;
      duplex_ff     <= `PBM_RST_DUPLEX;
      strap_pend_ff <= 1'b1;
    end
    else if (rst_done)
    begin
      loopback_ff   <= `PBM_RST_LOOPBACK; // [RULE_01]
      speed_ff      <= `PBM_RST_SPEED;
      an_en_ff      <= `PBM_RST_AN_EN;
      pwrdn_ff      <= pin_pd;
      isolate_ff    <= `PBM_RST_ISOLATE;
      duplex_ff     <= duplex_strap; // [RULE_09]
      strap_pend_ff <= 1'b0;
    end
    else
    begin
      pwrdn_ff      <= nxt_pwrdn; // [RULE_06]
      strap_pend_ff <= 1'b0;
      if (strap_pend_ff)
        duplex_ff   <= duplex_strap; // [RULE_09]
      else if (wr_hit)
        duplex_ff   <= reg_wdata[`PBM_BIT_DUPLEX];
      if (wr_hit)
      begin
        loopback_ff <= reg_wdata[`PBM_BIT_LOOPBACK]; // [RULE_03]
        speed_ff    <= reg_wdata[`PBM_BIT_SPEED]; // [RULE_04]
        an_en_ff    <= reg_wdata[`PBM_BIT_AN_EN]; // [RULE_05]
        isolate_ff  <= reg_wdata[`PBM_BIT_ISOLATE]; // [RULE_08]
      end
    end
  end

  // register reads keep working in power down and isolate
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      rdata_ff <= 16'h0000;
    else if (rd_req)
      rdata_ff <= nxt_rdata; // [RULE_02]
  end

  // datapath selection
  wire        tx_ok     = live && !isolate_ff; // [RULE_10]
  wire [3:0]  nxt_rxd   = loopback_ff ? mii_txd : line_rxd; // [RULE_03]
  wire        nxt_rx_dv = loopback_ff ? (mii_tx_en && tx_ok) : line_rx_dv;
  wire        nxt_tx_en = tx_ok && !loopback_ff && mii_tx_en;

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      rxd_ff   <= 4'h0;
      rx_dv_ff <= 1'b0;
      txd_ff   <= 4'h0;
      tx_en_ff <= 1'b0;
    end
    else
    begin
      rxd_ff   <= live ? nxt_rxd : 4'h0; // [RULE_06]
      rx_dv_ff <= live && nxt_rx_dv;
      txd_ff   <= tx_ok ? mii_txd : 4'h0; // [RULE_10]
      tx_en_ff <= nxt_tx_en;
    end
  end

  assign reg_rdata   = rdata_ff;
  assign mii_rxd     = rxd_ff;
  assign mii_rx_dv   = rx_dv_ff;
  assign mii_rx_oe   = !isolate_ff; // [RULE_08]
  assign line_txd    = txd_ff;
  assign line_tx_en  = tx_en_ff;
  assign speed_100   = an_en_ff ? an_speed_100 : speed_ff; // [RULE_05]
  assign full_duplex = an_en_ff ? an_full_duplex : duplex_ff; // [RULE_09]
  assign power_down  = pd_req; // [RULE_07]
  assign soft_reset  = rst_busy; // [RULE_01]

endmodule // pbm_ctrl

// ==== testbench/pbm_ctrl_chk.sv ====
/* port checker for pbm_ctrl.
   bound to every pbm_ctrl instance, sees its ports only. */
`timescale 1ns/1ps
module pbm_ctrl_chk
  import pbm_pkg::*;
(
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        rstn,
  // register port
  input wire logic        reg_sel,
  input wire logic        reg_we,
  input wire logic [4:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  // pins, mii and status
  input wire logic        irq_powerdown_pin_n,
  input wire logic        an_speed_100,
  input wire logic        mii_rx_dv,
  input wire logic        mii_rx_oe,
  input wire logic        line_tx_en,
  input wire logic        speed_100,
  input wire logic        full_duplex,
  input wire logic        power_down,
  input wire logic        soft_reset
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  logic [5:0] cnt_ff;
  wire        wr_ok = reg_sel && reg_we && reg_addr == 5'h00 && !soft_reset;
  // counts busy cycles so the length is checked without a long repetition
  always_ff @(posedge clk_sys or negedge rstn)
    if (!rstn) cnt_ff <= 6'h00;
    else cnt_ff <= soft_reset ? cnt_ff + 6'h01 : 6'h00;
  a_srst_start: assert property (wr_ok && reg_wdata[15] |=> soft_reset) else $error("no reset start");
  a_srst_len: assert property (cnt_ff <= 6'h19 && (!$fell(soft_reset) || cnt_ff == 6'h19))
    else $error("reset length");
  a_rd_busy: assert property (reg_sel && !reg_we && reg_addr == 5'h00 && soft_reset |=> reg_rdata[15])
    else $error("busy bit");
  a_iso_oe: assert property (wr_ok && !reg_wdata[15] |=> mii_rx_oe == !$past(reg_wdata[10]))
    else $error("isolate oe");
  a_iso_tx: assert property (!mii_rx_oe |=> !line_tx_en) else $error("isolate tx");
  a_forced_mode: assert property (wr_ok && !reg_wdata[15] && !reg_wdata[12] |=>
    speed_100 == $past(reg_wdata[13]) && full_duplex == $past(reg_wdata[8])) else $error("forced mode");
  a_an_follow: assert property (wr_ok && !reg_wdata[15] && reg_wdata[12] |=> speed_100 == an_speed_100)
    else $error("an speed");
  a_pin_pd: assert property (!irq_powerdown_pin_n |-> power_down) else $error("pin power down");
  // the pin must have set bit 11, so power down outlasts the pin itself
  a_pin_latch: assert property (!irq_powerdown_pin_n ##1 irq_powerdown_pin_n |-> power_down)
    else $error("pin latch");
  a_pd_blank: assert property (power_down |=> !mii_rx_dv && !line_tx_en) else $error("pd blank");
  c_srst: cover property ($fell(soft_reset));
  c_iso: cover property (!mii_rx_oe);
  c_pd: cover property (power_down);
endmodule // pbm_ctrl_chk
bind pbm_ctrl pbm_ctrl_chk u_chk (.clk_sys, .rstn, .reg_sel, .reg_we, .reg_addr, .reg_wdata, .reg_rdata,
  .irq_powerdown_pin_n, .an_speed_100, .mii_rx_dv, .mii_rx_oe, .line_tx_en, .speed_100, .full_duplex,
  .power_down, .soft_reset);

// ==== testbench/pbm_mac_model.sv ====
/* mac side model: random transmit nibbles, receive lines as the wire shows them.
   assumes the bench clock. */
`timescale 1ns/1ps
module pbm_mac_model (
  // clock
  input  wire logic       clk_sys,
  // receive from the phy
  input  wire logic       rx_oe,
  input  wire logic [4:0] rx_drv,
  output logic      [4:0] rx_wire,
  // transmit to the phy
  output logic      [4:0] tx
);
  integer     seed = 69190;
  logic [4:0] last = 5'h00;
  // released lines have no pull, so show a changing pattern rather than stale data
  assign rx_wire = rx_oe ? rx_drv : ~last;
  always @(posedge clk_sys) last <= rx_wire;
  initial tx = 5'h00;
  always @(negedge clk_sys) tx = 5'($random(seed));
endmodule // pbm_mac_model

// ==== testbench/testbench.sv ====
/* self-checking bench for pbm_ctrl.
   assumes the mac model and the bound checker. */
`timescale 1ns/1ps
module testbench;
  logic        clk_sys = 0, rstn = 0, reg_sel = 0, reg_we = 0, pin_n = 1, an_spd = 0, rd_taken = 0;
  logic        an_fd = 0, strap = 1;
  logic [4:0]  addr = 5'h00;
  logic [15:0] wdata = 16'h0000, rdata;
  logic [4:0]  tx, rx, rx_wire, prev_tx;
  logic [3:0]  ltxd;
  logic        oe, ltx_en, spd, fd, pd, srst;
  logic [15:0] exp_q[$];
  integer      errors = 0, total_checks = 0, n;
  always #20 clk_sys = ~clk_sys;
  pbm_ctrl uut (.clk_sys, .rstn, .reg_sel, .reg_we, .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata),
    .irq_powerdown_pin_n(pin_n), .duplex_strap(strap), .an_speed_100(an_spd), .an_full_duplex(an_fd),
    .mii_tx_en(tx[4]), .mii_txd(tx[3:0]), .mii_rxd(rx[3:0]), .mii_rx_dv(rx[4]), .mii_rx_oe(oe),
    .line_rxd(4'h5), .line_rx_dv(1'b1), .line_txd(ltxd), .line_tx_en(ltx_en), .speed_100(spd),
    .full_duplex(fd), .power_down(pd), .soft_reset(srst));
  pbm_mac_model mac (.clk_sys, .rx_oe(oe), .rx_drv(rx), .rx_wire, .tx);
  task automatic ck(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic we, input logic [4:0] a, input logic [15:0] d);
    @(negedge clk_sys);
    {reg_sel, reg_we, addr, wdata} = {1'b1, we, a, d};
    @(negedge clk_sys);
    reg_sel = 0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    acc(1'b0, a, 16'h0000);
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk_sys) prev_tx <= tx;
  always @(posedge clk_sys) rd_taken <= reg_sel && !reg_we;
  // read results land one edge after the request is taken
  always @(negedge clk_sys) if (rd_taken) ck(rdata, exp_q.pop_front());
  initial
  begin
    repeat (8) @(negedge clk_sys);
    rstn = 1;
    rd(5'h00, 16'h3100);
    rd(5'h03, 16'h0000);
    ck({rx_wire, ltx_en, ltxd}, {5'h15, prev_tx});
    acc(1'b1, 5'h00, 16'h5100);
    @(negedge clk_sys);
    ck({rx_wire, ltx_en}, {prev_tx, 1'b0});
    $display("done defaults and loopback");
    an_spd = 1;
    an_fd = 1;
    for (n = 0; n < 4; n++)
    begin
      acc(1'b1, 5'h00, {2'b00, n[1], 4'h0, n[0], 8'h00});
      ck({spd, fd}, n[1:0]);
    end
    acc(1'b1, 5'h00, 16'h1000);
    ck({spd, fd}, 2'b11);
    acc(1'b1, 5'h00, 16'h0400);
    @(negedge clk_sys);
    ck({oe, ltx_en}, 2'b00);
    rd(5'h00, 16'h0400);
    acc(1'b1, 5'h00, 16'h0800);
    ck(pd, 1'b1);
    @(negedge clk_sys);
    ck({rx_wire, ltx_en}, 6'h00);
    acc(1'b1, 5'h00, 16'h0000);
    ck(pd, 1'b0);
    pin_n = 0;
    @(negedge clk_sys);
    ck(pd, 1'b1);
    pin_n = 1;
    rd(5'h00, 16'h0800);
    $display("done modes, isolate and power down");
    // a low strap must be relatched into bit 8 when the soft reset ends
    strap = 0;
    acc(1'b1, 5'h00, 16'h0000);
    acc(1'b1, 5'h00, 16'h8000);
    rd(5'h00, 16'h8000);
    n = 0;
    while (srst && n < 60)
    begin
      @(negedge clk_sys);
      n++;
    end
    ck(n[15:0], 16'd23);
    rd(5'h00, 16'h3000);
    $display("done soft reset");
    strap = 1;
    acc(1'b1, 5'h00, 16'h8000);
    // a power-on reset in the middle of a soft reset must cancel it
    rstn = 0;
    @(negedge clk_sys);
    rstn = 1;
    @(negedge clk_sys);
    ck(srst, 1'b0);
    rd(5'h00, 16'h3100);
    $display("done mid-run reset");
    // let the last queued read be compared before the verdict
    repeat (2) @(negedge clk_sys);
    print_verdict;
  end
  initial
  begin
    #(1000 * 40);
    errors++;
    print_verdict;
  end
endmodule // testbench
